/* File: module_reset_clock_strap_unit.v */
// reset stretch, phy reference clock, strap capture and zero-cross timing
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "strap_unit_regs.vh"

// Overview of operation
// RULE_01: low chip reset holds all logic reset
// RULE_02: host holds reset 100 ms after supply
// RULE_03: phy reset follows chip reset, stretched
// RULE_04: 25 MHz phy clock only in mac mode
// RULE_05: board should wire phy reset with clock
// RULE_06: straps pick interface mode and boot source
// RULE_07: strap pins become led outputs after boot
// RULE_08: zero-cross input times line-cycle adaptation
// RULE_09: select strap low phy, high mac
// RULE_10: straps captured at reset release, then held
module module_reset_clock_strap_unit #(
  parameter STRETCH_CYCLES = `PHY_STRETCH_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  strap_in,
  input  wire        zero_cross_in,
  output reg         ext_phy_reset_n,
  output reg         ext_phy_ref_clock,
  output reg  [3:0]  led_out,
  output reg  [3:0]  led_oe,
  output reg         mac_phy_select,
  output reg         zero_cross_edge
);
  localparam ST_HOLD    = 3'b001;
  localparam ST_CAPTURE = 3'b010;
  localparam ST_RUN     = 3'b100;
  localparam [31:0] STRETCH = STRETCH_CYCLES;
  localparam [31:0] HALF_FULL = `REF_HALF_DIV - 1;
  localparam [2:0]  HALF      = HALF_FULL[2:0];

  wire [8:0] synced;
  reg  [2:0] state;
  reg        fill_done;
  reg  [7:0] strap;
  reg  [31:0] stretch_cnt;
  reg  [2:0] div_cnt;
  reg  [3:0] led_reg;
  reg        zc_prev;
  reg  [31:0] zc_timer;
  reg  [31:0] zc_period;
  reg  [31:0] zc_count;
  reg  [31:0] next_prdata;
  wire        zc_sync = synced[8];
  wire        is_mac  = strap[`STRAP_MACPHY_BIT];
  wire        setup   = psel && !penable;
  wire        wr_acc  = psel && penable && pwrite && pready;
  // a pulled-up line looks like a rise while the synchroniser fills
  wire        zc_rise = zc_sync && !zc_prev && (state == ST_RUN);

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `REG_STRAP_OFS) || (a == `REG_STATUS_OFS) ||
               (a == `REG_LED_OFS) || (a == `REG_ZC_PERIOD_OFS) ||
               (a == `REG_ZC_COUNT_OFS);
    end
  endfunction

  pin_sync #(.WIDTH(9)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({zero_cross_in, strap_in}),
    .sync_out (synced)
  );

  // strap pins are sampled through resistors; firmware takes them over later
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn) // see RULE_01
    begin
      state     <= ST_HOLD;
      strap     <= 8'h00;
      fill_done <= 1'b0;
    end
    else
    begin
      case (state)
        // two edges pass before the synchroniser shows real pin levels
        ST_HOLD:
        begin
          if (fill_done)
            state <= ST_CAPTURE;
          else
            fill_done <= 1'b1;
        end
        ST_CAPTURE:
        begin
          strap <= synced[7:0]; // see RULE_10 see RULE_06
          state <= ST_RUN;
        end
        ST_RUN:     state <= ST_RUN;
        default:    state <= ST_HOLD;
      endcase
    end
  end

  // phy reset asserts with the chip reset, releases after the stretch
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stretch_cnt     <= 32'h0000_0000;
      ext_phy_reset_n <= 1'b0; // see RULE_03
    end
    else if (state == ST_RUN && !ext_phy_reset_n)
    begin
      if (stretch_cnt >= STRETCH - 32'h0000_0001)
        ext_phy_reset_n <= 1'b1; // see RULE_03
      else
        stretch_cnt <= stretch_cnt + 32'h0000_0001;
    end
  end

  // divider toggles only in mac mode; phy mode parks the pin low
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt           <= 3'h0;
      ext_phy_ref_clock <= 1'b0;
    end
    else if (state == ST_RUN && is_mac) // see RULE_04 see RULE_09
    begin
      if (div_cnt == HALF)
      begin
        div_cnt           <= 3'h0;
        ext_phy_ref_clock <= ~ext_phy_ref_clock;
      end
      else
        div_cnt <= div_cnt + 3'h1;
    end
    else
    begin
      div_cnt           <= 3'h0;
      ext_phy_ref_clock <= 1'b0;
    end
  end

  // leds are released only after capture so they cannot upset the straps
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_reg        <= `LED_RESET;
      led_out        <= 4'h0;
      led_oe         <= 4'h0;
      mac_phy_select <= 1'b0;
    end
    else
    begin
      if (wr_acc && paddr == `REG_LED_OFS)
        led_reg <= pwdata[3:0];
      led_out        <= led_reg;
      led_oe         <= (state == ST_RUN) ? 4'hF : 4'h0; // see RULE_07
      mac_phy_select <= is_mac; // see RULE_09
    end
  end

  // line-cycle period measured between rising edges of the polarity input
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zc_prev         <= 1'b0;
      zc_timer        <= 32'h0000_0000;
      zc_period       <= 32'h0000_0000;
      zc_count        <= 32'h0000_0000;
      zero_cross_edge <= 1'b0;
    end
    else
    begin
      zc_prev         <= zc_sync;
      zero_cross_edge <= zc_rise; // see RULE_08
      if (zc_rise)
      begin
        zc_period <= zc_timer;
        zc_timer  <= 32'h0000_0001;
        zc_count  <= zc_count + 32'h0000_0001;
      end
      else if (zc_timer != 32'hFFFF_FFFF)
        zc_timer <= zc_timer + 32'h0000_0001;
    end
  end

  always @*
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `REG_STRAP_OFS:     next_prdata = {24'h000000, strap};
      `REG_STATUS_OFS:    next_prdata = {27'h0000000, zc_sync,
                                         ext_phy_reset_n, state};
      `REG_LED_OFS:       next_prdata = {28'h0000000, led_reg};
      `REG_ZC_PERIOD_OFS: next_prdata = zc_period;
      `REG_ZC_COUNT_OFS:  next_prdata = zc_count;
      default:            next_prdata = 32'h0000_0000;
    endcase
  end

  // no wait state: ready and data are registered in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pready  <= 1'b1;
      pslverr <= !mapped(paddr);
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

/* File: phy_model.sv */
// external phy: counts reference clock rises while out of reset
`timescale 1ns/10ps
module phy_model (
  input  wire        ext_phy_reset_n,
  input  wire        ext_phy_ref_clock,
  output reg  [15:0] ref_rises
);
  initial ref_rises = 16'h0000;
  // reset wired with the clock, so a held phy ignores edges
  always @(posedge ext_phy_ref_clock or negedge ext_phy_reset_n)
    if (!ext_phy_reset_n)
      ref_rises <= 16'h0000;
    else
      ref_rises <= ref_rises + 16'h0001;
endmodule

/* File: pin_sync.v */
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

/* File: strap_unit_properties.sv */
// concurrent checks on the strap unit ports
`timescale 1ns/10ps
module strap_unit_properties #(
  parameter STRETCH_CYCLES = 16
) (
  input wire       pclk,
  input wire       presetn,
  input wire       zero_cross_in,
  input wire       ext_phy_reset_n,
  input wire       ext_phy_ref_clock,
  input wire [3:0] led_oe,
  input wire       mac_phy_select,
  input wire       zero_cross_edge
);
  localparam int lo = STRETCH_CYCLES;
  localparam int hi = STRETCH_CYCLES + 4;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence half_hi;
    ext_phy_ref_clock [*4];
  endsequence
  sequence half_lo;
    !ext_phy_ref_clock [*4];
  endsequence
  a_reset_state: assert property (
    $rose(presetn) |-> !ext_phy_reset_n && led_oe == 4'h0)
    else $error("outputs left reset state early");
  a_stretch_low: assert property (
    $rose(presetn) |-> !ext_phy_reset_n [*8])
    else $error("phy reset released too soon");
  a_stretch_end: assert property (
    $rose(presetn) |-> ##[lo:hi] ext_phy_reset_n)
    else $error("phy reset not released in time");
  a_stretch_hold: assert property (
    ext_phy_reset_n |=> ext_phy_reset_n)
    else $error("phy reset dropped without chip reset");
  a_ref_mac_only: assert property (
    ext_phy_ref_clock |-> mac_phy_select)
    else $error("reference clock in phy mode");
  a_ref_rate: assert property (
    $rose(ext_phy_ref_clock) |-> half_hi ##1 half_lo ##1 ext_phy_ref_clock)
    else $error("reference clock period wrong");
  a_mode_held: assert property (
    ext_phy_reset_n |-> $stable(mac_phy_select))
    else $error("captured mode changed");
  a_led_drive: assert property (
    ext_phy_reset_n |-> led_oe == 4'hF)
    else $error("led pins not driven");
  a_zc_edge: assert property (
    $rose(zero_cross_in) |-> ##[1:5] zero_cross_edge)
    else $error("zero cross edge missed");
  a_zc_once: assert property (
    zero_cross_edge |=> !zero_cross_edge)
    else $error("zero cross pulse too long");
endmodule
bind module_reset_clock_strap_unit strap_unit_properties #(
  .STRETCH_CYCLES(STRETCH_CYCLES)
) strap_unit_properties_i (.pclk(pclk), .presetn(presetn),
  .zero_cross_in(zero_cross_in), .ext_phy_reset_n(ext_phy_reset_n),
  .ext_phy_ref_clock(ext_phy_ref_clock), .led_oe(led_oe),
  .mac_phy_select(mac_phy_select), .zero_cross_edge(zero_cross_edge));

/* File: strap_unit_regs.vh */
// register offsets, fields, reset values and timing counts for the strap unit
`ifndef STRAP_UNIT_REGS_VH
`define STRAP_UNIT_REGS_VH
`define REG_STRAP_OFS      12'h000
`define REG_STATUS_OFS     12'h004
`define REG_LED_OFS        12'h008
`define REG_ZC_PERIOD_OFS  12'h00C
`define REG_ZC_COUNT_OFS   12'h010
`define STRAP_ISOLATE_BIT  0
`define STRAP_SPEED_BIT    1
`define STRAP_ADDR3_BIT    2
`define STRAP_CFG_BIT      3
`define STRAP_ADDR4_BIT    4
`define STRAP_MACPHY_BIT   5
`define STRAP_BOOT_BIT     6
`define STRAP_DUPLEX_BIT   7
`define STRAP_WIDTH        8
`define LED_RESET          4'h0
`define LED_WIDTH          4
`define SYS_CLOCK_HZ       200000000
`define REF_CLOCK_HZ       25000000
`define REF_HALF_DIV       ((`SYS_CLOCK_HZ / `REF_CLOCK_HZ) / 2)
`define PHY_STRETCH_US     1000
`define PHY_STRETCH_CYC    ((`PHY_STRETCH_US * (`SYS_CLOCK_HZ / 1000000)))
`endif

/* File: tb.sv */
// testbench for the strap unit
`timescale 1ns/10ps
module tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [7:0]  strap_in = 8'hA5;
  reg         zero_cross_in = 1'b0;
  wire [31:0] prdata;
  wire [3:0]  led_out, led_oe;
  wire [15:0] rises;
  wire        pready, pslverr, ext_phy_reset_n, ext_phy_ref_clock;
  wire        mac_phy_select, zero_cross_edge;
  reg  [31:0] rd;
  reg         er;
  reg  [15:0] n0;
  integer     failures = 0;
  integer     comparisons = 0;
  always #2.5 pclk = ~pclk;
  module_reset_clock_strap_unit #(
    .STRETCH_CYCLES(16)
  ) module_reset_clock_strap_unit_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .strap_in(strap_in), .zero_cross_in(zero_cross_in),
    .ext_phy_reset_n(ext_phy_reset_n), .ext_phy_ref_clock(ext_phy_ref_clock),
    .led_out(led_out), .led_oe(led_oe), .mac_phy_select(mac_phy_select),
    .zero_cross_edge(zero_cross_edge));
  phy_model phy_model_i (.ext_phy_reset_n(ext_phy_reset_n),
    .ext_phy_ref_clock(ext_phy_ref_clock), .ref_rises(rises));
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task test_done;
  begin
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // straps stay put across release so the capture sees them settled
  task rst(input [7:0] s);
    integer i;
  begin
    @(posedge pclk);
    presetn <= 1'b0;
    strap_in <= s;
    repeat (16) @(posedge pclk);
    chk("held", {led_oe, ext_phy_reset_n}, 0);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("stretch", ext_phy_reset_n, 0);
    i = 0;
    while (ext_phy_reset_n !== 1'b1 && i < 100)
    begin
      @(posedge pclk);
      i = i + 1;
    end
    chk("released", ext_phy_reset_n, 1);
  end
  endtask
  initial
  begin
    rst(8'hA5);
    apb(12'h000, 1'b0, 0);
    chk("strap", rd, 32'h000000A5);
    chk("mode", mac_phy_select, 1);
    strap_in <= 8'h00;
    apb(12'h000, 1'b0, 0);
    chk("held strap", rd, 32'h000000A5);
    n0 = rises;
    repeat (80) @(posedge pclk);
    chk("ref rises", rises - n0, 10);
    apb(12'h008, 1'b1, 32'h00000005);
    apb(12'h008, 1'b0, 0);
    chk("led", {rd[7:0], led_oe, led_out}, 16'h05F5);
    apb(12'h100, 1'b0, 0);
    chk("unmapped", er, 1);
    repeat (2)
    begin
      zero_cross_in <= 1'b1;
      repeat (20) @(posedge pclk);
      zero_cross_in <= 1'b0;
      repeat (20) @(posedge pclk);
    end
    apb(12'h010, 1'b0, 0);
    chk("zc edges", rd, 2);
    apb(12'h00C, 1'b0, 0);
    chk("zc period", rd, 32'h00000028);
    // pulled-up idle level across reset must not count as an edge
    zero_cross_in <= 1'b1;
    rst(8'h5A);
    chk("mode", mac_phy_select, 0);
    apb(12'h010, 1'b0, 0);
    chk("zc after reset", rd, 0);
    n0 = rises;
    repeat (80) @(posedge pclk);
    chk("ref rises", rises - n0, 0);
    apb(12'h008, 1'b0, 0);
    chk("led reset", rd, 0);
    test_done;
  end
  initial
  begin
    #20000;
    failures = failures + 1;
    test_done;
  end
endmodule
